//--- acsf_map.svh
`ifndef ACSF_MAP_SVH
`define ACSF_MAP_SVH
// ****************
// register offsets
// ****************
`define ACSF_PROGRAM_STATUS_FLAGS_OFS 12'h086
`define ACSF_WORK_OFS 12'h100
`define ACSF_CTRL_OFS 12'h104
`define ACSF_SAVE_OFS 12'h108
// ****************
// flag field positions
// ****************
`define ACSF_CAUSE_HI 7
`define ACSF_CAUSE_LO 6
`define ACSF_UPPER_BIT 5
`define ACSF_MIDDLE_BIT 4
`define ACSF_UNUSED_BIT 3
`define ACSF_CARRY_BIT 2
`define ACSF_HALF_BIT 1
`define ACSF_ZERO_BIT 0
// ****************
// reset values
// ****************
`define ACSF_WORK_RST 8'h00
`define ACSF_FLAGS_RST 3'h0
`define ACSF_CAUSE_RST 2'h3
`define ACSF_CTRL_RST 2'h0
`endif

//--- acsf_pkg.sv
package acsf_pkg;
  typedef enum logic [1:0] {
    ACSF_CAUSE_WDT = 2'h0,
    ACSF_CAUSE_RSVD = 2'h1,
    ACSF_CAUSE_LVD = 2'h2,
    ACSF_CAUSE_PIN = 2'h3
  } acsf_cause_e;
  typedef enum logic [2:0] {
    ACSF_OP_NONE = 3'h0,
    ACSF_OP_ARITH = 3'h1,
    ACSF_OP_LOGIC = 3'h3,
    ACSF_OP_ROT = 3'h2,
    ACSF_OP_CMP = 3'h6,
    ACSF_OP_BRANCH = 3'h7
  } acsf_op_e;
  typedef enum logic [1:0] {
    ACSF_ST_IDLE = 2'h0,
    ACSF_ST_WRESP = 2'h1,
    ACSF_ST_RRESP = 2'h2
  } acsf_st_e;
endpackage

//--- acsf_flag_calc.sv
`timescale 1ns/1ns
`default_nettype none
`include "acsf_map.svh"
// ****************
// alu flag derivation
// ****************
module acsf_flag_calc (
  input wire logic [2:0] opKind,
  input wire logic [7:0] result,
  input wire logic carryOut,
  input wire logic nibbleCarry,
  output logic [2:0] flagsOut,
  output logic carryUsed
);
  wire isArith = opKind == 3'h1;
  wire isRot = opKind == 3'h2;
  wire isCmp = opKind == 3'h6;
  assign carryUsed = isArith | isRot | isCmp;
  // carry: add carry / sub no borrow / rotate out 1 / compare >= 0
  assign flagsOut[2] = carryOut;
  // half carry from low nibble, arithmetic only
  assign flagsOut[1] = nibbleCarry;
  assign flagsOut[0] = result == 8'h00;
endmodule
`default_nettype wire

//--- acsf_core.sv
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "acsf_map.svh"
// How it works
// - an 8-bit work register carries data between the alu and data memory.
// - alu results set zero, carry and half-carry flags in the status register.
// - the work register has no data memory address, so bank-0 moves never hit it.
// - interrupt entry leaves the work register and flags untouched.
// - save copies work register and flags to buffers, restore loads them back.
// - bits 7:6 hold the last reset cause: 00 watchdog, 01 reserved, 10 lvd, 11 pin.
// - bit 5 reads 1 at or below the upper detector level when that option is set.
// - bit 4 reads 1 at or below the middle detector level when that option is set.
// - carry is set on add carry, sub no borrow, rotate out 1, compare not negative.
// - half carry is set on low nibble carry or no low nibble borrow.
// - zero is set when an arithmetic, logic or branch result is zero.
// - bit set and bit clear only reach read/write bits.
module acsf_core (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic aluValid,
  input wire logic [2:0] aluOp,
  input wire logic [7:0] aluResult,
  input wire logic aluCarry,
  input wire logic aluNibbleCarry,
  input wire logic aluWriteWork,
  input wire logic memLoadValid,
  input wire logic [7:0] memLoadData,
  input wire logic saveStrobe,
  input wire logic restoreStrobe,
  input wire logic interruptEntry,
  input wire logic upperBelow,
  input wire logic middleBelow,
  input wire logic bitOpValid,
  input wire logic bitOpSet,
  input wire logic [2:0] bitOpIndex,
  input wire logic [1:0] resetCause,
  output logic [7:0] work_register,
  output logic [7:0] program_status_flags
);
  // ****************
  // reset release
  // ****************
  logic rstSync1_ff;
  logic rstSync2_ff;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rstSync1_ff <= 1'b0;
      rstSync2_ff <= 1'b0;
    end else begin
      rstSync1_ff <= 1'b1;
      rstSync2_ff <= rstSync1_ff;
    end
  end
  wire rstN = rstSync2_ff;

  // ****************
  // state
  // ****************
  logic [7:0] work_ff;
  logic [2:0] alu_ff;
  logic [1:0] cause_ff;
  logic causeTaken_ff;
  logic upper_ff;
  logic middle_ff;
  logic [1:0] ctrl_ff;
  logic [7:0] saveWork_ff;
  logic [7:0] saveFlags_ff;
  acsf_pkg::acsf_st_e st_ff;
  logic [31:0] rdata_ff;
  logic [1:0] bresp_ff;
  logic [1:0] rresp_ff;
  logic [7:0] flagsOut_ff;
  logic [11:0] awAddr_ff;
  logic awHave_ff;
  logic [31:0] wData_ff;
  logic [3:0] wStrb_ff;
  logic wHave_ff;

  // ****************
  // alu flag calculation
  // ****************
  logic [2:0] calcFlags;
  logic calcCarryUsed;
  acsf_flag_calc u_calc (
    .opKind(aluOp),
    .result(aluResult),
    .carryOut(aluCarry),
    .nibbleCarry(aluNibbleCarry),
    .flagsOut(calcFlags),
    .carryUsed(calcCarryUsed)
  );
  wire arithOp = aluOp == acsf_pkg::ACSF_OP_ARITH;
  wire zeroOp = arithOp | aluOp == acsf_pkg::ACSF_OP_LOGIC | aluOp == acsf_pkg::ACSF_OP_BRANCH;

  // ****************
  // flag view
  // ****************
  wire upperShown = ctrl_ff[1] & upper_ff;
  wire middleShown = ctrl_ff[0] & middle_ff;
  wire [7:0] flagView = {cause_ff, upperShown, middleShown, 1'b0, alu_ff};

  // ****************
  // bus decode
  // ****************
  wire awTake = s_axi_awvalid & s_axi_awready;
  wire wTake = s_axi_wvalid & s_axi_wready;
  wire [11:0] wrAddr = awTake ? s_axi_awaddr : awAddr_ff;
  wire [31:0] wrData = wTake ? s_axi_wdata : wData_ff;
  wire [3:0] wrStrb = wTake ? s_axi_wstrb : wStrb_ff;
  wire wrReady = (awHave_ff | awTake) & (wHave_ff | wTake) & st_ff == acsf_pkg::ACSF_ST_IDLE;
  wire wrLow = wrReady & wrStrb[0];
  wire wrHitFlags = wrAddr == `ACSF_PROGRAM_STATUS_FLAGS_OFS;
  wire wrHitWork = wrAddr == `ACSF_WORK_OFS;
  wire wrHitCtrl = wrAddr == `ACSF_CTRL_OFS;
  wire wrMapped = wrHitFlags | wrHitWork | wrHitCtrl | wrAddr == `ACSF_SAVE_OFS;
  wire rdTake = s_axi_arvalid & s_axi_arready;
  wire rdFlags = s_axi_araddr == `ACSF_PROGRAM_STATUS_FLAGS_OFS;
  wire rdWork = s_axi_araddr == `ACSF_WORK_OFS;
  wire rdCtrl = s_axi_araddr == `ACSF_CTRL_OFS;
  wire rdSave = s_axi_araddr == `ACSF_SAVE_OFS;
  wire rdMapped = rdFlags | rdWork | rdCtrl | rdSave;
  wire [31:0] rdValue = rdFlags ? {24'h000000, flagView} :
    rdWork ? {24'h000000, work_ff} :
    rdCtrl ? {30'h0, ctrl_ff} :
    rdSave ? {16'h0000, saveFlags_ff, saveWork_ff} : 32'h00000000;

  // ****************
  // bit set/clear on read/write bits only
  // ****************
  function automatic logic bitWritable(input logic [2:0] idx);
    bitWritable = idx != 3'h5 && idx != 3'h4 && idx != 3'h3;
  endfunction
  wire bitOk = bitOpValid & bitWritable(bitOpIndex);
  wire [7:0] bitMask = 8'h01 << bitOpIndex;
  wire [7:0] bitApplied = bitOpSet ? (flagView | bitMask) : (flagView & ~bitMask);

  // ****************
  // next values
  // ****************
  logic [7:0] nxt_work;
  logic [2:0] nxt_alu;
  logic [1:0] nxt_cause;
  always_comb begin
    nxt_work = work_ff;
    nxt_alu = alu_ff;
    nxt_cause = cause_ff;
    // interruptEntry deliberately has no effect here
    if (wrLow && wrHitWork) begin
      nxt_work = wrData[7:0];
    end
    if (wrLow && wrHitFlags) begin
      nxt_alu = wrData[2:0];
      nxt_cause = wrData[7:6];
    end
    if (bitOk) begin
      nxt_alu = bitApplied[2:0];
      nxt_cause = bitApplied[7:6];
    end
    if (memLoadValid) begin
      nxt_work = memLoadData;
    end
    if (aluValid) begin
      if (aluWriteWork) begin
        nxt_work = aluResult;
      end
      if (calcCarryUsed) begin
        nxt_alu[`ACSF_CARRY_BIT] = calcFlags[2];
      end
      if (arithOp) begin
        nxt_alu[`ACSF_HALF_BIT] = calcFlags[1];
      end
      if (zeroOp) begin
        nxt_alu[`ACSF_ZERO_BIT] = calcFlags[0];
      end
    end
    if (restoreStrobe) begin
      nxt_work = saveWork_ff;
      nxt_alu = saveFlags_ff[2:0];
      nxt_cause = saveFlags_ff[7:6];
    end
  end

  // ****************
  // datapath registers
  // ****************
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      work_ff <= `ACSF_WORK_RST;
      alu_ff <= `ACSF_FLAGS_RST;
      upper_ff <= 1'b0;
      middle_ff <= 1'b0;
      saveWork_ff <= 8'h00;
      saveFlags_ff <= 8'h00;
      flagsOut_ff <= 8'h00;
    end else begin
      work_ff <= nxt_work;
      alu_ff <= nxt_alu;
      upper_ff <= upperBelow;
      middle_ff <= middleBelow;
      flagsOut_ff <= flagView;
      if (saveStrobe) begin
        saveWork_ff <= work_ff;
        saveFlags_ff <= flagView;
      end
    end
  end

  // ****************
  // reset cause capture after release
  // ****************
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      cause_ff <= `ACSF_CAUSE_RST;
      causeTaken_ff <= 1'b0;
    end else if (!causeTaken_ff) begin
      cause_ff <= resetCause;
      causeTaken_ff <= 1'b1;
    end else begin
      cause_ff <= nxt_cause;
    end
  end

  // ****************
  // control register
  // ****************
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      ctrl_ff <= `ACSF_CTRL_RST;
    end else if (wrLow && wrHitCtrl) begin
      ctrl_ff <= wrData[1:0];
    end
  end

  // ****************
  // axi4-lite slave
  // ****************
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      awHave_ff <= 1'b0;
      wHave_ff <= 1'b0;
      awAddr_ff <= 12'h000;
      wData_ff <= 32'h00000000;
      wStrb_ff <= 4'h0;
    end else begin
      if (wrReady) begin
        awHave_ff <= 1'b0;
        wHave_ff <= 1'b0;
      end else begin
        if (awTake) begin
          awHave_ff <= 1'b1;
          awAddr_ff <= s_axi_awaddr;
        end
        if (wTake) begin
          wHave_ff <= 1'b1;
          wData_ff <= s_axi_wdata;
          wStrb_ff <= s_axi_wstrb;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      st_ff <= acsf_pkg::ACSF_ST_IDLE;
      bresp_ff <= 2'h0;
      rresp_ff <= 2'h0;
      rdata_ff <= 32'h00000000;
    end else begin
      case (st_ff)
        acsf_pkg::ACSF_ST_IDLE: begin
          if (wrReady) begin
            st_ff <= acsf_pkg::ACSF_ST_WRESP;
            bresp_ff <= wrMapped ? 2'h0 : 2'h2;
          end else if (rdTake) begin
            st_ff <= acsf_pkg::ACSF_ST_RRESP;
            rdata_ff <= rdValue;
            rresp_ff <= rdMapped ? 2'h0 : 2'h2;
          end
        end
        acsf_pkg::ACSF_ST_WRESP: begin
          if (s_axi_bready) begin
            st_ff <= acsf_pkg::ACSF_ST_IDLE;
          end
        end
        acsf_pkg::ACSF_ST_RRESP: begin
          if (s_axi_rready) begin
            st_ff <= acsf_pkg::ACSF_ST_IDLE;
          end
        end
        default: begin
          st_ff <= acsf_pkg::ACSF_ST_IDLE;
        end
      endcase
    end
  end

  // ****************
  // registered handshake outputs
  // ****************
  logic awReady_ff;
  logic wReady_ff;
  logic arReady_ff;
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      awReady_ff <= 1'b0;
      wReady_ff <= 1'b0;
      arReady_ff <= 1'b0;
    end else begin
      // write address ready only on request, read address ready without one; keeps ar and aw takes apart
      awReady_ff <= st_ff == acsf_pkg::ACSF_ST_IDLE & s_axi_awvalid & !awHave_ff & !awTake
        & !wrReady;
      wReady_ff <= st_ff == acsf_pkg::ACSF_ST_IDLE & !wHave_ff & !wTake & !wrReady;
      arReady_ff <= st_ff == acsf_pkg::ACSF_ST_IDLE & !rdTake & !wrReady
        & !(awHave_ff | awTake | s_axi_awvalid);
    end
  end

  assign s_axi_awready = awReady_ff;
  assign s_axi_wready = wReady_ff;
  assign s_axi_arready = arReady_ff;
  assign s_axi_bvalid = st_ff == acsf_pkg::ACSF_ST_WRESP;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = st_ff == acsf_pkg::ACSF_ST_RRESP;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign work_register = work_ff;
  assign program_status_flags = flagsOut_ff;
endmodule
`default_nettype wire

//--- acsf_alu_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// alu stand-in
// ****
module acsf_alu_model (
  input wire logic go,
  input wire logic [2:0] op,
  input wire logic [7:0] opA,
  input wire logic [7:0] opB,
  output logic aluValid,
  output logic [2:0] aluOp,
  output logic [7:0] aluResult,
  output logic aluCarry,
  output logic aluNibbleCarry
);
  logic [8:0] sum;
  logic [8:0] dif;
  assign sum = opA + opB;
  assign dif = opA - opB;
  assign aluValid = go;
  assign aluOp = op;
  assign aluResult = op == 3'h1 ? sum[7:0] : op == 3'h3 ? opA & opB :
    op == 3'h2 ? {opA[6:0], opA[7]} : op == 3'h6 ? dif[7:0] : opA;
  assign aluCarry = op == 3'h2 ? opA[7] : op == 3'h6 ? !dif[8] : sum[8];
  assign aluNibbleCarry = opA[3:0] + opB[3:0] > 5'h0F;
endmodule
`default_nettype wire

//--- acsf_core_props.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// checker
// ****
module acsf_core_props (
  input wire logic clock,
  input wire logic nrst,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic aluValid,
  input wire logic [2:0] aluOp,
  input wire logic [7:0] aluResult,
  input wire logic aluCarry,
  input wire logic aluNibbleCarry,
  input wire logic aluWriteWork,
  input wire logic memLoadValid,
  input wire logic [7:0] memLoadData,
  input wire logic restoreStrobe,
  input wire logic interruptEntry,
  input wire logic upperBelow,
  input wire logic [7:0] work_register,
  input wire logic [7:0] program_status_flags
);
  wire logic aluGo = aluValid && !restoreStrobe;
  wire logic [7:0] pf = program_status_flags;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  property p_zero;
    aluGo && (aluOp == 3'h1 || aluOp == 3'h3 || aluOp == 3'h7)
      |-> ##2 pf[0] == ($past(aluResult, 2) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_carry;
    aluGo && (aluOp == 3'h1 || aluOp == 3'h2 || aluOp == 3'h6)
      |-> ##2 pf[2] == $past(aluCarry, 2);
  endproperty
  a_carry: assert property (p_carry) else $error("carry flag wrong");
  property p_half;
    aluGo && aluOp == 3'h1 |-> ##2 pf[1] == $past(aluNibbleCarry, 2);
  endproperty
  a_half: assert property (p_half) else $error("half carry wrong");
  property p_spare;
    pf[3] == 1'h0;
  endproperty
  a_spare: assert property (p_spare) else $error("bit 3 set");
  property p_upper;
    (!upperBelow) [*3] |-> !pf[5];
  endproperty
  a_upper: assert property (p_upper) else $error("upper flag wrong");
  property p_load;
    memLoadValid && !restoreStrobe && !(aluValid && aluWriteWork)
      |=> work_register == $past(memLoadData);
  endproperty
  a_load: assert property (p_load) else $error("load lost");
  property p_irq;
    interruptEntry && !aluValid && !memLoadValid && !restoreStrobe
      |=> $stable(work_register);
  endproperty
  a_irq: assert property (p_irq) else $error("work changed");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  c_alu: cover property (aluGo && aluOp == 3'h1);
  c_restore: cover property (restoreStrobe);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind acsf_core acsf_core_props u_props (
  .clock(clock),
  .nrst(nrst),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata),
  .aluValid(aluValid),
  .aluOp(aluOp),
  .aluResult(aluResult),
  .aluCarry(aluCarry),
  .aluNibbleCarry(aluNibbleCarry),
  .aluWriteWork(aluWriteWork),
  .memLoadValid(memLoadValid),
  .memLoadData(memLoadData),
  .restoreStrobe(restoreStrobe),
  .interruptEntry(interruptEntry),
  .upperBelow(upperBelow),
  .work_register(work_register),
  .program_status_flags(program_status_flags)
);
`default_nettype wire

//--- tb_accumulator_status_flags.sv
`timescale 1ns/1ns
`default_nettype none
`include "acsf_map.svh"
// ****
// bench
// ****
module tb_accumulator_status_flags;
  logic clock = 0, nrst = 0, go = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, aluWriteWork = 0;
  logic memLoadValid = 0, saveStrobe = 0, restoreStrobe = 0, interruptEntry = 0;
  logic upperBelow = 0, middleBelow = 0, bitOpValid = 0, bitOpSet = 0, ad;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [2:0] op = 0, bitOpIndex = 0, aluOp;
  logic [1:0] resetCause = 0, s_axi_bresp, s_axi_rresp, resp;
  logic [7:0] opA = 0, opB = 0, memLoadData = 0, aluResult, work_register;
  logic [7:0] program_status_flags;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic aluValid, aluCarry, aluNibbleCarry;
  int errorCnt = 0, nChecks = 0, mW, mF, mOpt, i, a, b, r, c;
  int ops[6] = '{1, 0, 3, 2, 7, 6};
  int sv[$];
  always #10 clock = ~clock;
  acsf_core uut (
    .clock(clock),
    .nrst(nrst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .aluValid(aluValid),
    .aluOp(aluOp),
    .aluResult(aluResult),
    .aluCarry(aluCarry),
    .aluNibbleCarry(aluNibbleCarry),
    .aluWriteWork(aluWriteWork),
    .memLoadValid(memLoadValid),
    .memLoadData(memLoadData),
    .saveStrobe(saveStrobe),
    .restoreStrobe(restoreStrobe),
    .interruptEntry(interruptEntry),
    .upperBelow(upperBelow),
    .middleBelow(middleBelow),
    .bitOpValid(bitOpValid),
    .bitOpSet(bitOpSet),
    .bitOpIndex(bitOpIndex),
    .resetCause(resetCause),
    .work_register(work_register),
    .program_status_flags(program_status_flags)
  );
  acsf_alu_model alu (
    .go(go),
    .op(op),
    .opA(opA),
    .opB(opB),
    .aluValid(aluValid),
    .aluOp(aluOp),
    .aluResult(aluResult),
    .aluCarry(aluCarry),
    .aluNibbleCarry(aluNibbleCarry)
  );
  task end_of_test;
    if (errorCnt == 0 && nChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    nChecks++;
    if (g !== e) begin
      errorCnt++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  function logic [7:0] ef();
    return {mF[7:6], upperBelow & mOpt[1], middleBelow & mOpt[0], 1'h0, mF[2:0]};
  endfunction
  task look;
    repeat (3) @(posedge clock);
    chk(work_register, mW);
    chk(program_status_flags, ef());
  endtask
  task rst(input int k);
    nrst <= 0;
    resetCause <= k[1:0];
    repeat (5) @(posedge clock);
    nrst <= 1;
    repeat (4) @(posedge clock);
    mW = 0;
    mF = k * 64;
    mOpt = 0;
  endtask
  task wr(input logic [11:0] adr, input logic [31:0] d);
    s_axi_awaddr <= adr;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    ad = 0;
    while (!ad) begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) begin
        ad = 1;
        resp = s_axi_bresp;
        s_axi_bready <= 0;
      end
    end
    @(posedge clock);
  endtask
  task rd(input logic [11:0] adr);
    s_axi_araddr <= adr;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    ad = 0;
    while (!ad) begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) begin
        ad = 1;
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 0;
      end
    end
    @(posedge clock);
  endtask
  task step(input int o, input int w);
    if (o == 0) w = 0;
    op <= o[2:0];
    opA <= a[7:0];
    opB <= b[7:0];
    go <= 1;
    aluWriteWork <= w[0];
    @(posedge clock);
    go <= 0;
    aluWriteWork <= 0;
    c = mF[2];
    case (o)
      1: begin
        r = a + b;
        c = r > 255;
        mF[1] = a % 16 + b % 16 > 15;
      end
      2: begin
        r = a * 2 + a / 128;
        c = a / 128;
      end
      3: r = a & b;
      6: begin
        r = a - b;
        c = a >= b;
      end
      default: r = a;
    endcase
    r = r & 255;
    mF[2] = c;
    if (o == 1 || o == 3 || o == 7) mF[0] = r == 0;
    if (w) mW = r;
    look;
  endtask
  initial begin
    void'($urandom(32'hDE2AECD8));
    for (i = 3; i >= 0; i--) begin
      rst(i);
      look;
    end
    for (i = 0; i < 60; i++) begin
      a = i % 4 ? $urandom % 256 : 0;
      b = i % 8 ? $urandom % 256 : a;
      step(ops[i % 6], $urandom % 2);
    end
    memLoadData <= $urandom % 256;
    memLoadValid <= 1;
    @(posedge clock);
    memLoadValid <= 0;
    mW = memLoadData;
    look;
    rd(`ACSF_WORK_OFS);
    chk(rdat, mW);
    wr(`ACSF_WORK_OFS, 32'h5A);
    mW = 8'h5A;
    interruptEntry <= 1;
    @(posedge clock);
    interruptEntry <= 0;
    look;
    saveStrobe <= 1;
    @(posedge clock);
    saveStrobe <= 0;
    sv.push_back(ef() * 256 + mW);
    a = 200;
    b = 100;
    step(1, 1);
    rd(`ACSF_SAVE_OFS);
    chk(rdat, sv[0]);
    restoreStrobe <= 1;
    @(posedge clock);
    restoreStrobe <= 0;
    mW = sv[0] % 256;
    mF = sv.pop_front() / 256;
    look;
    wr(`ACSF_CTRL_OFS, 32'h3);
    mOpt = 3;
    for (i = 0; i < 5; i++) begin
      if (i == 4) wr(`ACSF_CTRL_OFS, 32'h0);
      mOpt = i == 4 ? 0 : 3;
      upperBelow <= i[1] | i[2];
      middleBelow <= i[0] | i[2];
      look;
    end
    for (i = 0; i < 16; i++) begin
      bitOpIndex <= i[2:0];
      bitOpSet <= !i[3];
      bitOpValid <= 1;
      @(posedge clock);
      bitOpValid <= 0;
      if (i % 8 < 3 || i % 8 > 5) mF[i % 8] = !i[3];
      look;
    end
    mF = $urandom % 256 | 8;
    wr(`ACSF_PROGRAM_STATUS_FLAGS_OFS, mF);
    rd(`ACSF_PROGRAM_STATUS_FLAGS_OFS);
    chk(rdat, ef());
    wr(12'h010, 32'h1);
    chk(resp, 2'h2);
    rd(12'h010);
    chk(resp, 2'h2);
    look;
    end_of_test;
  end
  initial begin
    #200000;
    errorCnt++;
    end_of_test;
  end
endmodule
`default_nettype wire
